// file: easel_pkg.sv
package easel_pkg;
  // addressing modes
  typedef enum logic [1:0] {
    EASEL_MODE_S,
    EASEL_MODE_R,
    EASEL_MODE_V,
    EASEL_MODE_I
  } easel_mode_t;

  // formation types
  typedef enum logic [2:0] {
    EASEL_FORM_DIRECT,
    EASEL_FORM_INDEXED,
    EASEL_FORM_INDIRECT,
    EASEL_FORM_PREINDEX,
    EASEL_FORM_POSTINDEX
  } easel_form_t;

  // base file read address codes
  localparam logic [3:0] EASEL_BA_GR_TOP = 4'h7;
  localparam logic [3:0] EASEL_BA_ZERO_A = 4'h8;
  localparam logic [3:0] EASEL_BA_FLOAT_REG_ZERO = 4'h9;
  localparam logic [3:0] EASEL_BA_ZERO_B = 4'ha;
  localparam logic [3:0] EASEL_BA_FLOAT_REG_ONE = 4'hb;
  localparam logic [3:0] EASEL_BA_PB = 4'hc;
  localparam logic [3:0] EASEL_BA_SB = 4'hd;
  localparam logic [3:0] EASEL_BA_LB = 4'he;
  localparam logic [3:0] EASEL_BA_XB = 4'hf;
  localparam int EASEL_BA_BASE_POS = 3;

  // 32I register field patterns, opcode bits 12..16
  localparam logic [4:0] EASEL_RR_FLOAT_REG_ZERO = 5'h06;
  localparam logic [4:0] EASEL_RR_FLOAT_REG_ONE = 5'h0e;

  // index file selection outside I mode
  localparam logic [2:0] EASEL_IX_Y = 3'h5;
  localparam logic [2:0] EASEL_IX_X = 3'h7;

  // reset values
  localparam logic [31:0] EASEL_EA_RST = 32'h0000_0000;
  localparam logic [3:0] EASEL_BA_RST = 4'hc;

  // decoded instruction from the decoder side
  typedef struct packed {
    logic [15:0] opcode;        // opcode[15] is bit 1, opcode[0] is bit 16
    logic [15:0] displacement;
    easel_mode_t mode;
    logic reg_to_reg;           // 32I floating or integer register-to-register
    logic generic;
    logic rel_to_pc;            // sector or procedure relative
    logic [1:0] base_select;    // memory ref base: 0 pb,1 sb,2 lb,3 xb
    easel_form_t form;
  } easel_instr_t;

  // word answered by the storage unit for an indirect fetch
  typedef struct packed {
    logic [31:0] word;
    logic chain;                // location holds a further indirection
  } easel_ind_t;
endpackage

// file: easel_file_select.sv
`timescale 1ns/1ps
module easel_file_select (
  // instruction in stage 4
  input wire easel_pkg::easel_instr_t instr,
  input wire logic indirect_phase1,
  // selection
  output logic [3:0] base_file_read_addr,
  output logic [2:0] index_file_read_addr,
  output logic base_needed_flag
);
  import easel_pkg::*;

  // opcode bit k (1..16) sits at instr.opcode[16-k]
  logic [4:0] rr_field;
  logic force_base;

  always_comb begin
    rr_field = instr.opcode[4:0];
    force_base = (instr.mode != EASEL_MODE_I) || !instr.reg_to_reg;
    base_needed_flag = (instr.mode == EASEL_MODE_I) && !instr.reg_to_reg;
    base_file_read_addr = EASEL_BA_PB;
    if (indirect_phase1) begin
      base_file_read_addr = EASEL_BA_PB;
    end else if (force_base) begin
      if (instr.generic) begin
        base_file_read_addr = EASEL_BA_PB;
      end else begin
        base_file_read_addr = {2'b11, instr.base_select};
      end
    end else if (rr_field == EASEL_RR_FLOAT_REG_ZERO) begin
      base_file_read_addr = EASEL_BA_FLOAT_REG_ZERO;
    end else if (rr_field == EASEL_RR_FLOAT_REG_ONE) begin
      base_file_read_addr = EASEL_BA_FLOAT_REG_ONE;
    end else if (rr_field[1:0] == 2'b00) begin
      base_file_read_addr = {1'b0, rr_field[4:2]};
    end
    if (instr.mode == EASEL_MODE_I) begin
      index_file_read_addr = instr.opcode[4:2];
    end else if (instr.opcode[14]) begin
      index_file_read_addr = EASEL_IX_X;
    end else begin
      index_file_read_addr = EASEL_IX_Y;
    end
  end
endmodule // easel_file_select

// file: easel_address_former.sv
`timescale 1ns/1ps
// Functional notes
// - base and index file addresses come from opcode and mode in stage 4
// - base port word is 32 bits in two halves, index port 16 bits
// - base codes 0000..0111 read general register N, both halves
// - 1001 floating 0, 1011 floating 1, 1000 and 1010 read zero
// - 1100 procedure base high with zero low; 1101..1111 stack, link, auxiliary
// - relative and generic instructions use program counter low as low word
// - force base codes outside I mode and for I non-register ops; flag only the I non-register case
// - generic instructions select the procedure base
// - first phase of indirection selects procedure base to supply zero
// - procedure base is the default base selection
// - 32I register ops pick register from opcode bits 12..16
// - I mode index address is opcode bits 12..14
// - outside I mode opcode bit 2 picks Y or X index
// - form type is direct, indexed, indirect or indirect indexed
// - address formed in stages 5 and 6, loaded at end of stage 6 for direct and indexed forms
// - direct address is base plus displacement
// - indexed address is base plus index plus displacement
// - short indirection uses fetched procedure word as the address
// - multi-level indirection follows the chain to its end
// - long indirection uses fetched 32-bit word as the address
// - preindex: base plus index plus displacement, then resolve chain
// - postindex: base plus displacement, resolve chain, then add index
// - microcode-assisted formation stalls the pipeline front end
module easel_address_former (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pipeline beat strobes
  input wire logic stage4_end,
  input wire logic stage5_end,
  input wire logic stage6_end,
  // decoded instruction
  input wire easel_pkg::easel_instr_t instr,
  input wire logic [15:0] program_counter_low,
  // register file contents
  input wire logic [15:0] general_high [8],
  input wire logic [15:0] general_low [8],
  input wire logic [31:0] float_reg_zero,
  input wire logic [31:0] float_reg_one,
  input wire logic [15:0] procedure_base_high,
  input wire logic [31:0] stack_base,
  input wire logic [31:0] link_base,
  input wire logic [31:0] auxiliary_base,
  // indirect fetch with storage unit
  output logic ind_fetch_req,
  output logic [31:0] ind_fetch_addr,
  input wire logic ind_fetch_ack,
  input wire easel_pkg::easel_ind_t ind_fetch_data,
  // outputs
  output logic [3:0] base_file_read_addr,
  output logic [2:0] index_file_read_addr,
  output logic base_needed_flag,
  output logic [15:0] base_port_high,
  output logic [15:0] base_port_low,
  output logic [15:0] index_port_word,
  output logic [31:0] cache_addr,
  output logic cache_addr_load,
  output logic front_end_stall,
  output logic busy
);
  import easel_pkg::*;

  typedef enum logic [2:0] {
    EASEL_ST_IDLE,
    EASEL_ST_S5,
    EASEL_ST_S6,
    EASEL_ST_FETCH,
    EASEL_ST_DONE
  } easel_state_t;

  logic [3:0] ba_sel;
  logic [2:0] ix_sel;
  logic bn_sel;
  logic [15:0] bh_mux;
  logic [15:0] bl_mux;
  logic [15:0] ix_mux;
  logic [15:0] bl_file;
  logic phase1;

  easel_file_select u_select (
    .instr(instr),
    .indirect_phase1(phase1),
    .base_file_read_addr(ba_sel),
    .index_file_read_addr(ix_sel),
    .base_needed_flag(bn_sel)
  );

  // base and index read ports
  always_comb begin
    bh_mux = 16'h0000;
    bl_mux = 16'h0000;
    unique case (ba_sel)
      EASEL_BA_ZERO_A, EASEL_BA_ZERO_B: begin
        bh_mux = 16'h0000;
        bl_mux = 16'h0000;
      end
      EASEL_BA_FLOAT_REG_ZERO: {bh_mux, bl_mux} = float_reg_zero;
      EASEL_BA_FLOAT_REG_ONE: {bh_mux, bl_mux} = float_reg_one;
      EASEL_BA_PB: begin
        bh_mux = procedure_base_high;
        bl_mux = 16'h0000;
      end
      EASEL_BA_SB: {bh_mux, bl_mux} = stack_base;
      EASEL_BA_LB: {bh_mux, bl_mux} = link_base;
      EASEL_BA_XB: {bh_mux, bl_mux} = auxiliary_base;
      default: begin
        bh_mux = general_high[ba_sel[2:0]];
        bl_mux = general_low[ba_sel[2:0]];
      end
    endcase
    bl_file = bl_mux;
    if (instr.rel_to_pc || instr.generic) begin
      bl_mux = program_counter_low;
    end
    ix_mux = general_high[ix_sel];
  end

  // stage 4 capture
  logic [3:0] ba_reg, ba_next;
  logic [2:0] ix_reg, ix_next;
  logic bn_reg, bn_next;
  logic [15:0] bh_reg, bh_next;
  logic [15:0] bl_reg, bl_next;
  logic [15:0] xw_reg, xw_next;
  logic [15:0] disp_reg, disp_next;
  easel_form_t form_reg, form_next;

  // formation pipeline
  easel_state_t st_reg, st_next;
  logic [31:0] sum_reg, sum_next;
  logic [31:0] ea_reg, ea_next;
  logic load_reg, load_next;
  logic req_reg, req_next;
  logic [31:0] faddr_reg, faddr_next;
  // phase one reads the procedure base; its low half is the zero added after post-indexing
  logic [15:0] pz_reg, pz_next;

  logic [31:0] base_word;
  logic [31:0] index_word;
  logic [31:0] disp_word;
  logic needs_ucode;

  always_comb begin
    base_word = {bh_reg, bl_reg};
    index_word = {16'h0000, xw_reg};
    disp_word = {16'h0000, disp_reg};
    needs_ucode = (form_reg == EASEL_FORM_INDIRECT) || (form_reg == EASEL_FORM_PREINDEX) ||
                  (form_reg == EASEL_FORM_POSTINDEX);
    phase1 = (form_reg == EASEL_FORM_INDIRECT || form_reg == EASEL_FORM_POSTINDEX) &&
             (st_reg == EASEL_ST_S5);
  end

  // stage 4 registers
  always_comb begin
    ba_next = ba_reg;
    ix_next = ix_reg;
    bn_next = bn_reg;
    bh_next = bh_reg;
    bl_next = bl_reg;
    xw_next = xw_reg;
    disp_next = disp_reg;
    form_next = form_reg;
    // no new instruction is taken while the fetch chain runs
    if (stage4_end && !front_end_stall) begin
      ba_next = ba_sel;
      ix_next = ix_sel;
      bn_next = bn_sel;
      bh_next = bh_mux;
      bl_next = bl_mux;
      xw_next = ix_mux;
      disp_next = instr.displacement;
      form_next = instr.form;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ba_reg <= EASEL_BA_RST;
      ix_reg <= 3'h0;
      bn_reg <= 1'b0;
      bh_reg <= 16'h0000;
      bl_reg <= 16'h0000;
      xw_reg <= 16'h0000;
      disp_reg <= 16'h0000;
      form_reg <= EASEL_FORM_DIRECT;
    end else begin
      ba_reg <= ba_next;
      ix_reg <= ix_next;
      bn_reg <= bn_next;
      bh_reg <= bh_next;
      bl_reg <= bl_next;
      xw_reg <= xw_next;
      disp_reg <= disp_next;
      form_reg <= form_next;
    end
  end

  // formation sequence
  always_comb begin
    st_next = st_reg;
    sum_next = sum_reg;
    ea_next = ea_reg;
    load_next = 1'b0;
    req_next = req_reg;
    faddr_next = faddr_reg;
    pz_next = pz_reg;
    unique case (st_reg)
      EASEL_ST_IDLE: begin
        if (stage4_end) begin
          st_next = EASEL_ST_S5;
        end
      end
      EASEL_ST_S5: begin
        if (stage5_end) begin
          if (phase1) begin
            pz_next = bl_file;
          end
          unique case (form_reg)
            EASEL_FORM_DIRECT, EASEL_FORM_INDIRECT, EASEL_FORM_POSTINDEX:
              sum_next = base_word + disp_word;
            default:
              sum_next = base_word + index_word + disp_word;
          endcase
          st_next = EASEL_ST_S6;
        end
      end
      EASEL_ST_S6: begin
        if (stage6_end) begin
          if (needs_ucode) begin
            req_next = 1'b1;
            faddr_next = sum_reg;
            st_next = EASEL_ST_FETCH;
          end else begin
            ea_next = sum_reg;
            load_next = 1'b1;
            st_next = EASEL_ST_IDLE;
          end
        end
      end
      EASEL_ST_FETCH: begin
        if (ind_fetch_ack) begin
          // a chained word becomes the next fetch address
          if (ind_fetch_data.chain) begin
            faddr_next = ind_fetch_data.word;
          end else begin
            req_next = 1'b0;
            st_next = EASEL_ST_DONE;
            if (form_reg == EASEL_FORM_POSTINDEX) begin
              ea_next = ind_fetch_data.word + index_word + {16'h0000, pz_reg};
            end else begin
              ea_next = ind_fetch_data.word;
            end
          end
        end
      end
      EASEL_ST_DONE: begin
        load_next = 1'b1;
        st_next = EASEL_ST_IDLE;
      end
      default: st_next = EASEL_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= EASEL_ST_IDLE;
      sum_reg <= EASEL_EA_RST;
      ea_reg <= EASEL_EA_RST;
      load_reg <= 1'b0;
      req_reg <= 1'b0;
      faddr_reg <= EASEL_EA_RST;
      pz_reg <= 16'h0000;
    end else begin
      st_reg <= st_next;
      sum_reg <= sum_next;
      ea_reg <= ea_next;
      load_reg <= load_next;
      req_reg <= req_next;
      faddr_reg <= faddr_next;
      pz_reg <= pz_next;
    end
  end

  always_comb begin
    base_file_read_addr = ba_reg;
    index_file_read_addr = ix_reg;
    base_needed_flag = bn_reg;
    base_port_high = bh_reg;
    base_port_low = bl_reg;
    index_port_word = xw_reg;
    cache_addr = ea_reg;
    cache_addr_load = load_reg;
    ind_fetch_req = req_reg;
    ind_fetch_addr = faddr_reg;
    front_end_stall = (st_reg == EASEL_ST_FETCH) || (st_reg == EASEL_ST_DONE);
    busy = (st_reg != EASEL_ST_IDLE);
  end
endmodule // easel_address_former

// file: easel_store_model.sv
`timescale 1ns/1ps
module easel_store_model (
  // clock and reset
  input logic clk_sys,
  input logic rst_n,
  // indirect fetch
  input logic ind_fetch_req,
  input logic [31:0] ind_fetch_addr,
  output logic ind_fetch_ack,
  output easel_pkg::easel_ind_t ind_fetch_data,
  // scenario control
  input logic [1:0] chains,
  input logic slow
);
  import easel_pkg::*;
  logic [1:0] left;
  logic [2:0] wt;
  // each word points 1000h further on; chains counts extra levels
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ind_fetch_ack <= 1'b0;
      ind_fetch_data <= '0;
      left <= 2'h0;
      wt <= 3'h0;
    end else if (ind_fetch_ack || !ind_fetch_req) begin
      ind_fetch_ack <= 1'b0;
      // released data lines wander
      ind_fetch_data <= ~ind_fetch_data;
      wt <= slow ? 3'h3 : 3'h0;
      if (!ind_fetch_req) begin
        left <= chains;
      end
    end else if (wt != 3'h0) begin
      wt <= wt - 3'h1;
      ind_fetch_data <= ~ind_fetch_data;
    end else begin
      ind_fetch_ack <= 1'b1;
      ind_fetch_data <= {ind_fetch_addr + 32'h1000, left != 2'h0};
      if (left != 2'h0) begin
        left <= left - 2'h1;
      end
    end
  end
endmodule // easel_store_model

// file: easel_address_former_chk.sv
`timescale 1ns/1ps
module easel_address_former_chk (
  // clock and reset
  input logic clk_sys,
  input logic rst_n,
  // beats and instruction
  input logic stage4_end,
  input logic stage6_end,
  input easel_pkg::easel_instr_t instr,
  input logic [15:0] program_counter_low,
  // indirect fetch
  input logic ind_fetch_req,
  input logic [31:0] ind_fetch_addr,
  input logic ind_fetch_ack,
  input easel_pkg::easel_ind_t ind_fetch_data,
  // results
  input logic [3:0] base_file_read_addr,
  input logic [2:0] index_file_read_addr,
  input logic base_needed_flag,
  input logic [15:0] base_port_low,
  input logic cache_addr_load,
  input logic front_end_stall,
  input logic busy
);
  import easel_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire s4 = stage4_end && !front_end_stall;
  wire md_i = instr.mode == EASEL_MODE_I;
  property p_force; s4 && !md_i |=> base_file_read_addr[3:2] == 2'h3; endproperty
  a_force: assert property (p_force) else $error("base not forced");
  property p_flag; s4 && md_i |=> base_needed_flag == !$past(instr.reg_to_reg); endproperty
  a_flag: assert property (p_flag) else $error("base flag wrong");
  property p_ixi; s4 && md_i |=> index_file_read_addr == $past(instr.opcode[4:2]); endproperty
  a_ixi: assert property (p_ixi) else $error("index addr wrong");
  property p_ixo; s4 && !md_i |=> index_file_read_addr == ($past(instr.opcode[14]) ? 3'h7 : 3'h5); endproperty
  a_ixo: assert property (p_ixo) else $error("x or y wrong");
  property p_pcl; s4 && (instr.rel_to_pc || instr.generic) |=> base_port_low == $past(program_counter_low); endproperty
  a_pcl: assert property (p_pcl) else $error("pc low missing");
  property p_pbl;
    s4 && !md_i && !instr.rel_to_pc && !instr.generic && instr.base_select == 2'h0
      |=> base_file_read_addr == 4'hc && base_port_low == 16'h0;
  endproperty
  a_pbl: assert property (p_pbl) else $error("pb low not zero");
  property p_load;
    stage6_end && busy && instr.form inside {EASEL_FORM_DIRECT, EASEL_FORM_INDEXED}
      |=> cache_addr_load ##1 !cache_addr_load;
  endproperty
  a_load: assert property (p_load) else $error("load pulse wrong");
  property p_chain; ind_fetch_ack && ind_fetch_data.chain |=> ind_fetch_req && ind_fetch_addr == $past(ind_fetch_data.word); endproperty
  a_chain: assert property (p_chain) else $error("chain not followed");
  property p_final; ind_fetch_ack && !ind_fetch_data.chain |=> !ind_fetch_req && front_end_stall ##1 cache_addr_load; endproperty
  a_final: assert property (p_final) else $error("final fetch wrong");
  c_load: cover property (cache_addr_load);
  c_chain: cover property (ind_fetch_ack && ind_fetch_data.chain);
  c_stall: cover property (front_end_stall);
endmodule // easel_address_former_chk

// file: easel_address_former_test.sv
`timescale 1ns/1ps
module easel_address_former_test;
  import easel_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic stage4_end = 1'b0, stage5_end = 1'b0, stage6_end = 1'b0, slow = 1'b0;
  logic [1:0] chains = 2'h0;
  easel_instr_t instr = '0;
  logic [15:0] general_high [8], general_low [8];
  logic [15:0] program_counter_low = 16'h5a5a, procedure_base_high = 16'h0123;
  logic [31:0] float_reg_zero = 32'h3c00_0001, float_reg_one = 32'h3d00_0002;
  logic [31:0] stack_base = 32'h0002_0010, link_base = 32'h0003_0020, auxiliary_base = 32'h0004_0030;
  logic ind_fetch_req, ind_fetch_ack, base_needed_flag, cache_addr_load, front_end_stall, busy;
  logic [31:0] ind_fetch_addr, cache_addr, ew, bases [4];
  easel_ind_t ind_fetch_data;
  logic [3:0] base_file_read_addr, eb;
  logic [2:0] index_file_read_addr;
  logic [15:0] base_port_high, base_port_low, index_port_word;
  int err_total = 0, n_compared = 0;
  easel_address_former i_easel_address_former (.clk_sys, .rst_n, .stage4_end, .stage5_end, .stage6_end, .instr,
    .program_counter_low, .general_high, .general_low, .float_reg_zero, .float_reg_one, .procedure_base_high,
    .stack_base, .link_base, .auxiliary_base, .ind_fetch_req, .ind_fetch_addr, .ind_fetch_ack, .ind_fetch_data,
    .base_file_read_addr, .index_file_read_addr, .base_needed_flag, .base_port_high, .base_port_low,
    .index_port_word, .cache_addr, .cache_addr_load, .front_end_stall, .busy);
  easel_store_model i_easel_store_model (.clk_sys, .rst_n, .ind_fetch_req, .ind_fetch_addr, .ind_fetch_ack,
    .ind_fetch_data, .chains, .slow);
  always #25 clk_sys = ~clk_sys;
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one instruction through stages 4, 5 and 6
  task beat(input logic [3:0] xba, input logic [31:0] xea, input logic ea_on);
    int n;
    n = 0;
    stage4_end = 1'b1;
    @(posedge clk_sys); #1;
    stage4_end = 1'b0;
    chk("base addr", {28'h0, xba}, {28'h0, base_file_read_addr});
    stage5_end = 1'b1;
    @(posedge clk_sys); #1;
    stage5_end = 1'b0;
    stage6_end = 1'b1;
    @(posedge clk_sys); #1;
    stage6_end = 1'b0;
    while (cache_addr_load !== 1'b1 && n < 40) begin
      @(posedge clk_sys); #1;
      n++;
    end
    chk("load pulse", 32'h1, {31'h0, cache_addr_load});
    if (ea_on) chk("eff addr", xea, cache_addr);
    @(posedge clk_sys); #1;
    chk("busy", 32'h0, {31'h0, busy});
  endtask
  initial begin
    #200000;
    err_total++;
    end_of_test;
  end
  initial begin
    for (int i = 0; i < 8; i++) begin
      general_high[i] = 16'h0011 + 16'(i) * 16'h0100;
      general_low[i] = 16'h0a00 + 16'(i);
    end
    bases = '{{procedure_base_high, 16'h0}, stack_base, link_base, auxiliary_base};
    instr.displacement = 16'h0040;
    instr.mode = EASEL_MODE_V;
    repeat (10) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk("reset addr", 32'hc, {28'h0, base_file_read_addr});
    instr.base_select = 2'h1;
    beat(4'hd, stack_base + 32'h40, 1'b1);
    instr.form = EASEL_FORM_INDEXED;
    for (int b = 0; b < 4; b++) begin
      instr.base_select = 2'(b);
      instr.opcode[14] = b[0];
      ew = {16'h0, general_high[b[0] ? 7 : 5]};
      beat(4'hc + 4'(b), bases[b] + ew + 32'h40, 1'b1);
      chk("index word", ew, {16'h0, index_port_word});
    end
    instr.mode = EASEL_MODE_I;
    instr.form = EASEL_FORM_DIRECT;
    instr.reg_to_reg = 1'b1;
    for (int k = 0; k < 10; k++) begin
      instr.opcode[4:0] = k == 0 ? 5'h06 : k == 1 ? 5'h0e : 5'(k - 2) << 2;
      eb = k == 0 ? 4'h9 : k == 1 ? 4'hb : 4'(k - 2);
      ew = k == 0 ? float_reg_zero : k == 1 ? float_reg_one : {general_high[k - 2], general_low[k - 2]};
      beat(eb, 32'h0, 1'b0);
      chk("base word", ew, {base_port_high, base_port_low});
      chk("index addr", {29'h0, instr.opcode[4:2]}, {29'h0, index_file_read_addr});
    end
    instr.reg_to_reg = 1'b0;
    instr.base_select = 2'h3;
    instr.opcode = 16'h0;
    beat(4'hf, auxiliary_base + 32'h40, 1'b1);
    chk("needed flag", 32'h1, {31'h0, base_needed_flag});
    instr.mode = EASEL_MODE_V;
    instr.generic = 1'b1;
    beat(4'hc, {procedure_base_high, program_counter_low} + 32'h40, 1'b1);
    chk("pc low", {16'h0, program_counter_low}, {16'h0, base_port_low});
    instr.generic = 1'b0;
    instr.base_select = 2'h0;
    instr.opcode[14] = 1'b1;
    for (int f = 0; f < 3; f++) begin
      instr.form = easel_form_t'(f + 2);
      chains = 2'(2 - f);
      slow = f != 1;
      ew = bases[0] + 32'h40 + 32'(32'h1000 * (3 - f));
      ew = ew + (f != 0 ? {16'h0, general_high[7]} : 32'h0);
      beat(4'hc, ew, 1'b1);
    end
    rst_n = 1'b0;
    #1;
    chk("reset ea", 32'h0, cache_addr);
    chk("reset addr", 32'hc, {28'h0, base_file_read_addr});
    chk("reset flag", 32'h0, {31'h0, base_needed_flag});
    @(posedge clk_sys);
    #1 rst_n = 1'b1;
    instr.form = EASEL_FORM_DIRECT;
    instr.base_select = 2'h2;
    beat(4'he, link_base + 32'h40, 1'b1);
    end_of_test;
  end
endmodule // easel_address_former_test
bind easel_address_former easel_address_former_chk i_easel_address_former_chk (.clk_sys, .rst_n, .stage4_end,
  .stage6_end, .instr, .program_counter_low, .ind_fetch_req, .ind_fetch_addr, .ind_fetch_ack, .ind_fetch_data,
  .base_file_read_addr, .index_file_read_addr, .base_needed_flag, .base_port_low, .cache_addr_load,
  .front_end_stall, .busy);
